/* File: sgca_asserts.sv */
// Purpose: Port-level checks for sgca_top.
// Assumes: Pins are sampled by ref_clk through the design's synchroniser.
// Notes: Windows allow for the sync and edge-detect delay on each pin.
`timescale 1ns/1ps
module sgca_asserts #(
   parameter WATCH_W = 7
) (
   input wire ref_clk,
   input wire reset_n,
   input wire cs_n,
   input wire dout,
   input wire alert_port,
   input wire shutdown,
   input wire [7:0] config_reg,
   input wire [WATCH_W-1:0] watch_mask,
   input wire write_strobe,
   input wire [6:0] write_addr,
   input wire [7:0] write_data,
   input wire read_strobe,
   input wire [6:0] read_addr
);
   wire clr;
   // An arm write also drops the alert, so it counts as a legal clear.
   assign clr = (write_strobe && (write_addr == 7'h06 || (write_addr == 7'h04 && write_data[7])))
      || (read_strobe && read_addr == 7'h06);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   chk_strobe_pulse: assert property (write_strobe |=> !write_strobe)
      else $error("write strobe longer than one cycle");
   chk_nop_silent: assert property (write_strobe |-> write_addr != 7'h00)
      else $error("no-op command executed as a write");
   chk_idle_quiet: assert property (cs_n [*8] |-> !write_strobe && $stable(config_reg))
      else $error("state changed while deselected");
   chk_dout_hold: assert property (cs_n [*8] |-> $stable(dout))
      else $error("serial output moved while deselected");
   chk_cfg_load: assert property (write_strobe && write_addr == 7'h04 |-> ##[0:1] config_reg == write_data)
      else $error("configuration not loaded from command");
   chk_mask_load: assert property (write_strobe && write_addr == 7'h06
      |-> ##[0:1] watch_mask == write_data[WATCH_W-1:0])
      else $error("mask not loaded from command");
   chk_shutdown_bit: assert property ($changed(config_reg[0]) |-> ##[0:1] shutdown != config_reg[0])
      else $error("shutdown does not follow run bit");
   chk_alert_sticky: assert property ($fell(alert_port) |-> clr || $past(clr) || $past(clr, 2))
      else $error("alert cleared without mask access");
   chk_alert_masked: assert property ($rose(alert_port) |-> watch_mask != 0)
      else $error("alert raised with every port masked");
   cover property ($rose(alert_port));
   cover property (read_strobe && read_addr == 7'h06);
   cover property (write_strobe && write_addr == 7'h04);
endmodule
bind sgca_top sgca_asserts #(.WATCH_W(WATCH_W)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
   .cs_n(cs_n), .dout(dout), .alert_port(alert_port), .shutdown(shutdown),
   .config_reg(config_reg), .watch_mask(watch_mask), .write_strobe(write_strobe),
   .write_addr(write_addr), .write_data(write_data), .read_strobe(read_strobe),
   .read_addr(read_addr));

/* File: sgca_change_detect.v */
// Purpose: Port change alert with snapshot, mask and one-shot arming.
// Assumes: Port levels already synchronised to ref_clk.
// Notes: Set of the alert wins over a mask-access clear in the same cycle; an arm write wins over both.
`timescale 1ns/1ps
`include "sgca_defs.vh"
module sgca_change_detect #(
   parameter WIDTH = 7
) (
   input wire ref_clk,
   input wire reset_n,
   input wire [WIDTH-1:0] port_level,
   input wire [WIDTH-1:0] watch_mask,
   input wire arm_write,
   input wire disarm_write,
   input wire mask_access,
   output reg armed,
   output reg alert
);
   reg [WIDTH-1:0] snapshot;
   wire change_seen;
   assign change_seen = armed && (|((port_level ^ snapshot) & watch_mask));
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         snapshot <= {WIDTH{1'b0}};
         armed <= 1'b0;
         alert <= 1'b0;
      end else begin
         if (arm_write) begin
            snapshot <= port_level;
            armed <= 1'b1;
            alert <= 1'b0;
         end else begin
            if (disarm_write || change_seen) begin
               armed <= 1'b0;
            end
            // The alert stays latched until the mask register is touched or an arm write occurs.
            if (change_seen) begin
               alert <= 1'b1;
            end else if (mask_access) begin
               alert <= 1'b0;
            end
         end
      end
   end
endmodule

/* File: sgca_defs.vh */
// Purpose: Shared constants for the serial GPIO command front end.
// Assumes: Plain Verilog-2005 tools.
// Notes: Offsets are command addresses in the seven-bit address field.
`ifndef SGCA_DEFS_VH
`define SGCA_DEFS_VH
`define SGCA_WORD_W 16
`define SGCA_RW_BIT 15
`define SGCA_ADDR_HI 14
`define SGCA_ADDR_LO 8
`define SGCA_DATA_HI 7
`define SGCA_ADDR_NOP 7'h00
`define SGCA_ADDR_CONFIG 7'h04
`define SGCA_ADDR_MASK 7'h06
`define SGCA_CONFIG_RUN_BIT 0
`define SGCA_CONFIG_WATCH_BIT 7
`define SGCA_CONFIG_RESET 8'h00
`define SGCA_MASK_RESET 7'h00
`define SGCA_WATCH_W 7
`endif

/* File: sgca_host_model.sv */
// Purpose: Serial master model that shifts frames into sgca_top.
// Assumes: Pins move only on ref_clk rising edges, 160 ns serial period.
// Notes: The clock stands still between frames; data idles at its last bit inverted.
`timescale 1ns/1ps
module sgca_host_model (
   input wire ref_clk,
   output reg sclk,
   output reg cs_n,
   output reg din,
   input wire dout
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
   end
   task xfer(input [31:0] w, input integer n, input reg sel, output [31:0] r);
      integer i;
      begin
         r = 32'h0;
         cs_n <= ~sel;
         repeat (8) @(posedge ref_clk);
         for (i = n - 1; i >= 0; i = i - 1) begin
            din <= w[i];
            repeat (8) @(posedge ref_clk);
            sclk <= 1'b1;
            r = {r[30:0], dout};
            repeat (8) @(posedge ref_clk);
            sclk <= 1'b0;
         end
         repeat (8) @(posedge ref_clk);
         cs_n <= 1'b1;
         din <= ~din;
         repeat (8) @(posedge ref_clk);
      end
   endtask
endmodule

/* File: sgca_sync2.v */
// Purpose: Two flip-flop synchroniser for a vector of pin levels.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module sgca_sync2 #(
   parameter WIDTH = 1,
   // Each bit resets to the idle level of its pin, so no false edge follows reset.
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire clk,
   input wire reset_n,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= RESET_VAL;
         sync_out <= RESET_VAL;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

/* File: sgca_top.v */
// Purpose: Serial command front end of a GPIO expander with change alert.
// Assumes: ref_clk is much faster than the serial clock; pins are asynchronous.
// Notes: Serial clock edges are found by sampling after two flip-flops.
// What this block does
// - Input bits reappear on output 15.5 clocks later, launched on falling clock.
// - A write to command address zero is a no-op that changes nothing; a read there returns 8'h00.
// - Sixteen-bit shift register captures data on rising clock while selected.
// - With select high, clock edges shift nothing and change no state.
// - Select rising copies the shift register into a latch and executes it.
// - With more than sixteen bits, only the last sixteen are kept.
// - Read has top bit one, seven address bits, eight discarded dummy bits.
// - After a read, select rising loads the low byte with register data.
// - Read data shifts out during the next command as its second byte.
// - Reset clears control registers and starts in shutdown.
// - A watched change raises the active-high alert without naming the port.
// - Seven-bit mask chooses which watched ports are compared.
// - Detection works whether a watched port is input or output.
// - Configuration write with watch bit set refreshes the seven-bit snapshot.
// - That write arms detection and lowers alert; stays armed until cleared.
// - Any armed difference, even brief, latches the alert high.
// - Only a mask register access or an arming config write clears the latched alert.
// - When alert sets detection is disarmed until re-armed by config write.
// - Shutdown forces ports to input and pull-ups off, registers kept.
// - Serial output is always driven, never high impedance.
`timescale 1ns/1ps
`include "sgca_defs.vh"
module sgca_top #(
   parameter WATCH_W = `SGCA_WATCH_W
) (
   input wire ref_clk,
   input wire reset_n,
   input wire sclk,
   input wire cs_n,
   input wire din,
   output reg dout,
   input wire [WATCH_W-1:0] watched_ports,
   output reg alert_port,
   output reg shutdown,
   output reg [7:0] config_reg,
   output reg [WATCH_W-1:0] watch_mask,
   output reg write_strobe,
   output reg [6:0] write_addr,
   output reg [7:0] write_data,
   output reg read_strobe,
   output reg [6:0] read_addr,
   input wire [7:0] ext_read_data
);
   localparam ST_IDLE = 2'b01;
   localparam ST_SEL = 2'b10;

   wire sclk_s;
   wire cs_n_s;
   wire din_s;
   wire [WATCH_W-1:0] ports_s;
   reg sclk_d;
   reg [1:0] state;
   reg [`SGCA_WORD_W-1:0] shifter;
   reg [`SGCA_WORD_W-1:0] cmd_latch;
   reg arm_write;
   reg disarm_write;
   reg mask_access;
   wire armed;
   wire alert;
   wire sclk_rise;
   wire sclk_fall;
   wire [6:0] cmd_addr;
   wire cmd_read;
   reg [7:0] read_value;

   // Address match used by the command execute decodes; the readback case does its own match.
   function addr_hit;
      input [6:0] addr;
      input [6:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   // The select pin idles high, so its synchroniser resets high; a low reset value
   // would look like a select pulse and execute a stale command after reset.
   sgca_sync2 #(
      .WIDTH(3 + WATCH_W),
      .RESET_VAL({1'b0, 1'b1, 1'b0, {WATCH_W{1'b0}}})
   ) u_sync (
      .clk(ref_clk),
      .reset_n(reset_n),
      .async_in({sclk, cs_n, din, watched_ports}),
      .sync_out({sclk_s, cs_n_s, din_s, ports_s})
   );

   sgca_change_detect #(.WIDTH(WATCH_W)) u_detect (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .port_level(ports_s),
      .watch_mask(watch_mask),
      .arm_write(arm_write),
      .disarm_write(disarm_write),
      .mask_access(mask_access),
      .armed(armed),
      .alert(alert)
   );

   // Edges are honoured only while selected, so other traffic is ignored.
   assign sclk_rise = sclk_s && !sclk_d && !cs_n_s;
   assign sclk_fall = !sclk_s && sclk_d && !cs_n_s;
   assign cmd_addr = shifter[`SGCA_ADDR_HI:`SGCA_ADDR_LO];
   assign cmd_read = shifter[`SGCA_RW_BIT];

   // Register readback for the addresses this block owns; others come from outside.
   always @* begin
      case (cmd_addr)
         `SGCA_ADDR_CONFIG: read_value = config_reg;
         `SGCA_ADDR_MASK: read_value = {1'b0, watch_mask};
         `SGCA_ADDR_NOP: read_value = 8'h00;
         default: read_value = ext_read_data;
      endcase
   end

   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_d <= 1'b0;
         state <= ST_IDLE;
         shifter <= 16'h0000;
         cmd_latch <= 16'h0000;
         dout <= 1'b0;
         config_reg <= `SGCA_CONFIG_RESET;
         watch_mask <= `SGCA_MASK_RESET;
         shutdown <= 1'b1;
         alert_port <= 1'b0;
         arm_write <= 1'b0;
         disarm_write <= 1'b0;
         mask_access <= 1'b0;
         write_strobe <= 1'b0;
         write_addr <= 7'h00;
         write_data <= 8'h00;
         read_strobe <= 1'b0;
         read_addr <= 7'h00;
      end else begin
         sclk_d <= sclk_s;
         arm_write <= 1'b0;
         disarm_write <= 1'b0;
         mask_access <= 1'b0;
         write_strobe <= 1'b0;
         read_strobe <= 1'b0;
         alert_port <= alert;
         shutdown <= ~config_reg[`SGCA_CONFIG_RUN_BIT];
         if (sclk_rise) begin
            shifter <= {shifter[`SGCA_WORD_W-2:0], din_s};
         end
         if (sclk_fall) begin
            // The top bit was shifted in 15.5 serial clocks before this edge.
            dout <= shifter[`SGCA_WORD_W-1];
         end
         case (state)
            ST_IDLE: begin
               // Shifter and dout hold while deselected.
               if (!cs_n_s) begin
                  state <= ST_SEL;
               end
            end
            ST_SEL: begin
               if (cs_n_s) begin
                  state <= ST_IDLE;
                  cmd_latch <= shifter;
                  if (cmd_read) begin
                     shifter[`SGCA_DATA_HI:0] <= read_value;
                     read_strobe <= 1'b1;
                     read_addr <= cmd_addr;
                     if (addr_hit(cmd_addr, `SGCA_ADDR_MASK)) begin
                        mask_access <= 1'b1;
                     end
                  end else if (!addr_hit(cmd_addr, `SGCA_ADDR_NOP)) begin
                     write_strobe <= 1'b1;
                     write_addr <= cmd_addr;
                     write_data <= shifter[`SGCA_DATA_HI:0];
                     if (addr_hit(cmd_addr, `SGCA_ADDR_CONFIG)) begin
                        config_reg <= shifter[`SGCA_DATA_HI:0];
                        if (shifter[`SGCA_CONFIG_WATCH_BIT]) begin
                           arm_write <= 1'b1;
                        end else begin
                           disarm_write <= 1'b1;
                        end
                     end
                     if (addr_hit(cmd_addr, `SGCA_ADDR_MASK)) begin
                        watch_mask <= shifter[WATCH_W-1:0];
                        mask_access <= 1'b1;
                     end
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

/* File: tb_sgca_top.sv */
// Purpose: Self-checking bench for sgca_top.
// Assumes: The host model runs every frame; ports move on ref_clk edges.
// Notes: Expected values follow from the command word format, the reset values and the alert rules.
`timescale 1ns/1ps
module tb_sgca_top;
   reg ref_clk = 1'b0;
   reg reset_n = 1'b0;
   reg [6:0] wp = 7'h00;
   reg [7:0] ext = 8'h00;
   wire sclk, cs_n, din, dout, alert, sd, ws, rs;
   wire [7:0] cfg, wd;
   wire [6:0] msk, wa, ra;
   reg [31:0] r;
   integer fails = 0;
   integer tests_run = 0;
   always #5 ref_clk = ~ref_clk;
   sgca_top DUT (.ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n), .din(din),
      .dout(dout), .watched_ports(wp), .alert_port(alert), .shutdown(sd), .config_reg(cfg),
      .watch_mask(msk), .write_strobe(ws), .write_addr(wa), .write_data(wd),
      .read_strobe(rs), .read_addr(ra), .ext_read_data(ext));
   sgca_host_model host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wr(input [15:0] w);
      host.xfer({16'h0, w}, 16, 1'b1, r);
   endtask
   task ports(input [6:0] v);
      begin
         wp <= v;
         repeat (8) @(posedge ref_clk);
      end
   endtask
   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      #400000;
      fails = fails + 1;
      final_report;
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      chk("shutdown", sd, 16'h1);
      chk("config", cfg, 16'h0);
      chk("mask", msk, 16'h0);
      $display("test reset done");
      wr(16'h0401);
      chk("config", cfg, 16'h01);
      chk("shutdown", sd, 16'h0);
      host.xfer(32'h00860403, 24, 1'b1, r);
      chk("config", cfg, 16'h03);
      chk("echo", r[15:0], 16'h0186);
      host.xfer(32'h0000047f, 16, 1'b0, r);
      chk("config", cfg, 16'h03);
      wr(16'h00ff);
      chk("config", cfg, 16'h03);
      chk("echo", r[15:0], 16'h0403);
      wr(16'h0f40);
      chk("waddr", wa, 16'h0f);
      chk("wdata", wd, 16'h40);
      $display("test write done");
      ext <= 8'ha5;
      host.xfer(32'h9055, 16, 1'b1, r);
      chk("raddr", ra, 16'h10);
      wr(16'h0000);
      chk("read", r[15:0], 16'h90a5);
      host.xfer(32'h8400, 16, 1'b1, r);
      wr(16'h0000);
      chk("cfgread", r[15:0], 16'h8403);
      $display("test read done");
      wr(16'h067f);
      wr(16'h0481);
      chk("alert", alert, 16'h0);
      ports(7'h08);
      ports(7'h00);
      chk("alert", alert, 16'h1);
      host.xfer(32'h8600, 16, 1'b1, r);
      chk("alert", alert, 16'h0);
      ports(7'h08);
      chk("alert", alert, 16'h0);
      wr(16'h0481);
      chk("alert", alert, 16'h0);
      ports(7'h00);
      chk("alert", alert, 16'h1);
      wr(16'h0601);
      chk("alert", alert, 16'h0);
      wr(16'h0481);
      ports(7'h10);
      chk("alert", alert, 16'h0);
      ports(7'h11);
      chk("alert", alert, 16'h1);
      $display("test alert done");
      final_report;
   end
endmodule
